// ---- core/periph_irq_pkg.sv ----
package periph_irq_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // Register byte addresses
  localparam logic [7:0] OFF_ENABLE_ONE = 8'h00;
  localparam logic [7:0] OFF_ENABLE_TWO = 8'h04;
  localparam logic [7:0] OFF_FLAGS_ONE = 8'h08;
  localparam logic [7:0] OFF_CORE_CTRL = 8'h0c;

  // Enable register one fields
  localparam int EN1_CONV_DONE = 6;
  localparam int EN1_SERIAL_RX = 5;
  localparam int EN1_SERIAL_TX = 4;
  localparam int EN1_SYNC_SERIAL = 3;
  localparam int EN1_CAPCMP_ONE = 2;
  localparam int EN1_PERIOD_MATCH = 1;
  localparam int EN1_COUNTER_OVF = 0;

  // Enable register two fields
  localparam int EN2_OSC_FAIL = 7;
  localparam int EN2_COMPARATOR_B = 6;
  localparam int EN2_COMPARATOR_A = 5;
  localparam int EN2_NVM_WRITE = 4;
  localparam int EN2_COLLISION = 3;
  localparam int EN2_LOWPOWER_WAKE = 2;
  localparam int EN2_CAPCMP_TWO = 0;

  // Flag register one uses the same positions as enable register one
  localparam int FLAG_CONV_DONE = 6;
  localparam int FLAG_SERIAL_RX = 5;
  localparam int FLAG_SERIAL_TX = 4;
  localparam int FLAG_SYNC_SERIAL = 3;
  localparam int FLAG_CAPCMP_ONE = 2;
  localparam int FLAG_PERIOD_MATCH = 1;
  localparam int FLAG_COUNTER_OVF = 0;

  // Core interrupt control fields
  localparam int CTRL_MASTER_EN = 7;
  localparam int CTRL_PERIPH_EN = 6;

  // Implemented-bit masks
  localparam logic [7:0] ENABLE_ONE_MASK = 8'h7f;
  localparam logic [7:0] ENABLE_TWO_MASK = 8'hfd;
  localparam logic [7:0] CORE_CTRL_MASK = 8'hc0;

  // Reset values
  localparam logic [7:0] ENABLE_ONE_RST = 8'h00;
  localparam logic [7:0] ENABLE_TWO_RST = 8'h00;
  localparam logic [7:0] FLAGS_ONE_RST = 8'h00;
  localparam logic [7:0] CORE_CTRL_RST = 8'h00;

  // Sticky flags kept by the flag bank, in bank order
  localparam int STICKY_N = 5;
endpackage

// ---- core/flag_bank_if.sv ----
`timescale 1ns/1ps
interface flag_bank_if #(parameter int N = 5);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] flags;
  modport bank (input set, input clr, output flags);
  modport user (output set, output clr, input flags);
endinterface

// ---- core/sticky_flag_bank.sv ----
`timescale 1ns/1ps
module sticky_flag_bank #(
  parameter int N = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  flag_bank_if.bank fb
);
  logic [N-1:0] flags_reg;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      // A set in the same cycle as a clear wins so no event is lost
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flags_reg[i] <= 1'b0;
        end else if (fb.set[i]) begin
          flags_reg[i] <= 1'b1;
        end else if (fb.clr[i]) begin
          flags_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign fb.flags = flags_reg;
endmodule // sticky_flag_bank

// ---- core/periph_irq_regs.sv ----
// Notes on behaviour
// - Enable register two holds osc fail, comparator b, comparator a, nvm write, collision and low-power wake enables in bits 7..2, bit 1 reads zero, bit 0 is capcmp two.
// - Every implemented enable bit is read/write, gates its source when one, and resets to zero.
// - No peripheral request reaches the core unless the peripheral global enable is set as well as the source enable.
// - A flag sets on its event whatever the state of its enable and of the master enable.
// - Flag register one holds conv done, rx, tx, sync serial, capcmp one, period match and counter overflow in bits 6..0, rx and tx read-only, bit 7 zero, all reset to zero.
// - The conv done flag sets when a conversion completes and clears only by software.
// - The rx flag follows a full receive buffer, which the serial port empties when its data register is read.
// - The tx flag reads one while the transmit buffer is empty and zero once it is written and full.
// - The sync serial flag sets when a transfer has taken place, and software clears it before leaving its handler.
// - In I2C master operation the sync serial flag also sets when an initiated start, stop, restart or acknowledge completes.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module periph_irq_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [periph_irq_pkg::ADDR_W-1:0] paddr,
  input wire logic [periph_irq_pkg::DATA_W-1:0] pwdata,
  output logic [periph_irq_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_done_evt,
  input wire logic rx_buf_full,
  input wire logic tx_buf_empty,
  input wire logic sync_serial_xfer_evt,
  input wire logic sync_serial_seq_evt,
  input wire logic i2c_master_mode,
  input wire logic capcmp_one_evt,
  input wire logic period_match_evt,
  input wire logic counter_ovf_evt,
  input wire logic [periph_irq_pkg::REG_W-1:0] flags_two_in,
  output logic core_irq_req
);
  localparam int N = periph_irq_pkg::STICKY_N;

  logic [7:0] enable_one_reg;
  logic [7:0] enable_two_reg;
  logic [7:0] core_ctrl_reg;
  logic rx_flag_reg;
  logic tx_flag_reg;
  logic [7:0] flags_one;
  logic access;
  logic wr;
  logic mapped;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;
  logic [N-1:0] sticky_set;
  logic [N-1:0] sticky_clr;

  flag_bank_if #(.N(N)) fb ();

  sticky_flag_bank #(.N(N)) u_bank (
    .pclk(pclk),
    .presetn(presetn),
    .fb(fb.bank)
  );

  // One wait state: pready rises in the second access cycle
  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign wbyte = pwdata[7:0];

  always_comb begin
    mapped = 1'b1;
    rd_byte = 8'h00;
    unique case (paddr)
      periph_irq_pkg::OFF_ENABLE_ONE: rd_byte = enable_one_reg;
      periph_irq_pkg::OFF_ENABLE_TWO: rd_byte = enable_two_reg;
      periph_irq_pkg::OFF_FLAGS_ONE: rd_byte = flags_one;
      periph_irq_pkg::OFF_CORE_CTRL: rd_byte = core_ctrl_reg;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready) begin
        prdata <= (mapped && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_one_reg <= periph_irq_pkg::ENABLE_ONE_RST;
    end else if (wr && paddr == periph_irq_pkg::OFF_ENABLE_ONE) begin
      enable_one_reg <= wbyte & periph_irq_pkg::ENABLE_ONE_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_two_reg <= periph_irq_pkg::ENABLE_TWO_RST;
    end else if (wr && paddr == periph_irq_pkg::OFF_ENABLE_TWO) begin
      enable_two_reg <= wbyte & periph_irq_pkg::ENABLE_TWO_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ctrl_reg <= periph_irq_pkg::CORE_CTRL_RST;
    end else if (wr && paddr == periph_irq_pkg::OFF_CORE_CTRL) begin
      core_ctrl_reg <= wbyte & periph_irq_pkg::CORE_CTRL_MASK;
    end
  end

  // Buffer-state flags follow the serial port; writes cannot touch them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_flag_reg <= 1'b0;
      tx_flag_reg <= 1'b0;
    end else begin
      rx_flag_reg <= rx_buf_full;
      tx_flag_reg <= tx_buf_empty;
    end
  end

  // Bank order: 4 conv done, 3 sync serial, 2 capcmp one, 1 period match, 0 counter ovf
  assign sticky_set = {conv_done_evt,
                       sync_serial_xfer_evt || (i2c_master_mode && sync_serial_seq_evt),
                       capcmp_one_evt, period_match_evt, counter_ovf_evt};
  // Writing a one clears a sticky flag; only software clears them
  assign sticky_clr = (wr && paddr == periph_irq_pkg::OFF_FLAGS_ONE) ?
                      {wbyte[periph_irq_pkg::FLAG_CONV_DONE], wbyte[3:0]} : '0;
  assign fb.set = sticky_set;
  assign fb.clr = sticky_clr;

  always_comb begin
    flags_one = 8'h00;
    flags_one[periph_irq_pkg::FLAG_CONV_DONE] = fb.flags[4];
    flags_one[periph_irq_pkg::FLAG_SERIAL_RX] = rx_flag_reg;
    flags_one[periph_irq_pkg::FLAG_SERIAL_TX] = tx_flag_reg;
    flags_one[3:0] = fb.flags[3:0];
  end

  // Gating stays level based, so stale flags fire as soon as enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_irq_req <= 1'b0;
    end else begin
      core_irq_req <= (|(flags_one & enable_one_reg) || |(flags_two_in & enable_two_reg))
                      && core_ctrl_reg[periph_irq_pkg::CTRL_PERIPH_EN]
                      && core_ctrl_reg[periph_irq_pkg::CTRL_MASTER_EN];
    end
  end
endmodule // periph_irq_regs

// ---- tb/periph_irq_sva.sv ----
`timescale 1ns/1ps
module periph_irq_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_buf_full,
  input wire logic tx_buf_empty,
  input wire logic core_irq_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd;
  assign rd = pready && !pwrite;
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  chk_err_decode: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h0c))
    else $error("pslverr wrong");
  chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  chk_en1_top: assert property (rd && paddr == 8'h00 |-> prdata[31:7] == 0)
    else $error("enable one bit 7 set");
  chk_en2_gap: assert property (rd && paddr == 8'h04 |-> !prdata[1] && prdata[31:8] == 0)
    else $error("enable two bit 1 set");
  chk_flag_top: assert property (rd && paddr == 8'h08 |-> prdata[31:7] == 0)
    else $error("flag bit 7 set");
  // Four held cycles cover the one-cycle mirror delay plus the read pipeline
  chk_rx_mirror: assert property (rx_buf_full[*4] ##0 (rd && paddr == 8'h08) |-> prdata[5])
    else $error("rx flag low");
  chk_tx_mirror: assert property ((!tx_buf_empty)[*4] ##0 (rd && paddr == 8'h08) |-> !prdata[4])
    else $error("tx flag high");
  cover property (core_irq_req);
  cover property (pslverr);
  cover property (rd && paddr == 8'h08 && prdata[5]);
endmodule // periph_irq_sva

// ---- tb/periph_model.sv ----
`timescale 1ns/1ps
module periph_model (
  input wire logic pclk,
  input wire logic [5:0] kick,
  output logic [5:0] ev
);
  // Events leave as one-cycle pulses, as a real peripheral strobes them
  always_ff @(posedge pclk) begin
    ev <= kick;
  end
endmodule // periph_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0, penable = 0, pwrite = 0, rx = 0, tx = 0, i2c = 0;
  logic [7:0] paddr = 8'h00, f2 = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, core_irq_req;
  logic [5:0] kick_r = 6'h00, ev;
  int n_mismatch = 0, compares = 0;
  initial forever #5 pclk = ~pclk;
  periph_model pm (.pclk, .kick(kick_r), .ev);
  periph_irq_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .conv_done_evt(ev[5]), .rx_buf_full(rx), .tx_buf_empty(tx),
    .sync_serial_xfer_evt(ev[3]), .sync_serial_seq_evt(ev[4]), .i2c_master_mode(i2c),
    .capcmp_one_evt(ev[2]), .period_match_evt(ev[1]), .counter_ovf_evt(ev[0]),
    .flags_two_in(f2), .core_irq_req);
  task automatic end_sim;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) begin
      n_mismatch++;
      end_sim;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input string s, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(s, e, rdat);
  endtask
  task automatic kick(input logic [5:0] k);
    @(posedge pclk);
    kick_r <= k;
    @(posedge pclk);
    kick_r <= 6'h00;
    repeat (3) @(posedge pclk);
  endtask
  task automatic q(input logic e);
    repeat (3) @(posedge pclk);
    chk("irq", {31'h0, e}, {31'h0, core_irq_req});
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd("en1", 8'h00, 0);
    rd("en2", 8'h04, 0);
    rd("fl1", 8'h08, 0);
    apb(1, 8'h00, 32'hff);
    rd("en1", 8'h00, 32'h7f);
    apb(1, 8'h04, 32'hff);
    rd("en2", 8'h04, 32'hfd);
    apb(1, 8'h10, 32'h1);
    chk("err", 1, {31'h0, rerr});
    rd("gap", 8'h10, 0);
    apb(1, 8'h00, 0);
    apb(1, 8'h04, 0);
    kick(6'h2f);
    rd("fl1", 8'h08, 32'h4f);
    apb(1, 8'h08, 0);
    rd("fl1", 8'h08, 32'h4f);
    apb(1, 8'h08, 32'h4f);
    rd("fl1", 8'h08, 0);
    kick(6'h10);
    rd("seq", 8'h08, 0);
    i2c <= 1;
    kick(6'h10);
    rd("seq", 8'h08, 32'h08);
    rx <= 1;
    tx <= 1;
    apb(1, 8'h08, 32'hff);
    rd("rxtx", 8'h08, 32'h30);
    rx <= 0;
    tx <= 0;
    apb(1, 8'h0c, 32'hc0);
    kick(6'h04);
    q(0);
    apb(1, 8'h08, 32'h04);
    rd("stale", 8'h08, 32'h00);
    apb(1, 8'h00, 32'h04);
    q(0);
    kick(6'h04);
    q(1);
    apb(1, 8'h0c, 32'h80);
    q(0);
    apb(1, 8'h0c, 32'h40);
    q(0);
    apb(1, 8'h0c, 32'hc0);
    apb(1, 8'h08, 32'h04);
    q(0);
    f2 <= 8'h80;
    apb(1, 8'h04, 32'h80);
    q(1);
    end_sim;
  end
endmodule // tb_top
bind periph_irq_regs periph_irq_sva chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .rx_buf_full, .tx_buf_empty, .core_irq_req);
